/* File: design/sbs_pkg.sv */
// Shared constants and types of the synchronous burst SRAM device logic.
// Assumes one clock domain; users write every reference as sbs_pkg::name.
package sbs_pkg;

    // ************************************************************
    // Register map (byte addresses on the Avalon-MM slave)
    // ************************************************************
    localparam logic [3:0]  REG_CTRL_OFS     = 4'h0;
    localparam logic [3:0]  REG_STATUS_OFS   = 4'h4;

    localparam int          CTRL_WIDE_POS    = 0;
    localparam int          STAT_SLEEP_POS   = 0;
    localparam int          STAT_ORDER_POS   = 1;
    localparam int          STAT_LOW_POS     = 2;
    localparam int          STAT_MASK_POS    = 4;
    localparam int          STAT_ABORT_POS   = 8;
    localparam int          STAT_WRPEND_POS  = 9;

    // ************************************************************
    // Reset values and cycle counts
    // ************************************************************
    localparam logic        SLEEP_RESET      = 1'b0;
    localparam logic        ORDER_RESET      = 1'b1;
    localparam logic [2:0]  SYNC_RESET       = 3'h0;
    localparam logic [2:0]  ORDER_SYNC_RESET = 3'h7;
    localparam logic [1:0]  BEAT_RESET       = 2'h0;
    localparam logic [1:0]  BEAT_STEP        = 2'h1;
    localparam int          SYNC_STAGES      = 3;
    localparam int          BUS_ANSWER_CYC   = 1;

    // Kind of the burst in progress
    typedef enum logic [1:0] {
        KIND_IDLE  = 2'b00,
        KIND_READ  = 2'b01,
        KIND_WRITE = 2'b10
    } sbs_kind_t;

endpackage

/* File: design/sbs_core_if.sv */
// Carrier between the top and its lane decoder and burst counter.
// Assumes all members are driven on the single clk domain of the top.
`timescale 1ns/1ps
interface sbs_core_if #(
    parameter int LANES = 4
);
    logic             writeSelN;
    logic [LANES-1:0] laneN;
    logic             wideMode;
    logic [LANES-1:0] laneMask;
    logic             writeOp;
    logic             writeAbort;
    logic             load;
    logic             advance;
    logic [1:0]       seed;
    logic             interleaved;
    logic [1:0]       curLow;
    logic [1:0]       nextLow;

    modport decoder (
        input  writeSelN,
        input  laneN,
        input  wideMode,
        output laneMask,
        output writeOp,
        output writeAbort
    );

    modport counter (
        input  load,
        input  advance,
        input  seed,
        input  interleaved,
        output curLow,
        output nextLow
    );
endinterface

/* File: design/sbs_lane_decode.sv */
// Byte-lane write decoder for the 18-bit and 36-bit organisations.
// Assumes strobes were sampled by the caller at the rising clock edge.
`timescale 1ns/1ps
module sbs_lane_decode (
    sbs_core_if.decoder core
);
    // ************************************************************
    // Lane decode
    // ************************************************************
    always_comb begin
        core.writeOp = ~core.writeSelN;
        if (core.writeSelN) begin
            core.laneMask = '0;
        end else if (core.wideMode) begin
            core.laneMask = ~core.laneN;
        end else begin
            // Upper lanes do not exist in the narrow organisation
            core.laneMask = '0;
            core.laneMask[1:0] = ~core.laneN[1:0];
        end
        core.writeAbort = core.writeOp && (core.laneMask == '0);
    end
endmodule

/* File: design/sbs_burst_count.sv */
// Two-bit burst counter with interleaved and linear order.
// Assumes load and advance are never high in the same cycle.
`timescale 1ns/1ps
module sbs_burst_count (
    input  wire logic   clk,
    input  wire logic   sys_rst,
    sbs_core_if.counter core
);
    typedef struct packed {
        logic [1:0] seed;
        logic [1:0] beat;
    } sbs_cnt_t;

    sbs_cnt_t cnt_reg;
    sbs_cnt_t cnt_next;

    function automatic logic [1:0] burstLow(input logic [1:0] seed, input logic [1:0] beat,
                                            input logic interleaved);
        if (interleaved) begin
            burstLow = seed ^ beat;
        end else begin
            burstLow = seed + beat;
        end
    endfunction

    // ************************************************************
    // Counter
    // ************************************************************
    always_comb begin
        cnt_next = cnt_reg;
        if (core.load) begin
            cnt_next.seed = core.seed;
            cnt_next.beat = sbs_pkg::BEAT_RESET;
        end else if (core.advance) begin
            cnt_next.beat = cnt_reg.beat + sbs_pkg::BEAT_STEP;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    assign core.curLow  = burstLow(cnt_reg.seed, cnt_reg.beat, core.interleaved);
    assign core.nextLow = burstLow(cnt_reg.seed, cnt_reg.beat + sbs_pkg::BEAT_STEP,
                                   core.interleaved);
endmodule

/* File: design/sbs_top.sv */
// Synchronous burst SRAM device: data pins, byte writes, burst order, sleep,
// and an Avalon-MM register slave. Assumes the controller drives the command
// pins on clk; sleep and burst-order pins may be asynchronous.
//
// The Avalon-MM register port and the placing of the registers were decided locally.
`timescale 1ns/1ps

module sbs_top #(
    parameter int   ADDR_W       = 18,
    parameter int   LANE_W       = 9,
    parameter int   LANES        = 4,
    parameter logic WIDE_DEFAULT = 1'b1
) (
    input  wire logic                    clk,
    input  wire logic                    sys_rst,
    input  wire logic                    chipSelectN,
    input  wire logic                    advance,
    input  wire logic                    writeSelectN,
    input  wire logic                    byte_lane_a_write_n,
    input  wire logic                    byte_lane_b_write_n,
    input  wire logic                    byte_lane_c_write_n,
    input  wire logic                    byte_lane_d_write_n,
    input  wire logic                    outputEnableN,
    input  wire logic                    sleep_request,
    input  wire logic                    burstOrderPin,
    input  wire logic                    burstOrderDriven,
    input  wire logic [ADDR_W-1:0]       address,
    input  wire logic [LANES*LANE_W-1:0] dataIn,
    output logic      [LANES*LANE_W-1:0] dataOut,
    output logic                         dataOe,
    input  wire logic [3:0]              avs_address,
    input  wire logic                    avs_read,
    input  wire logic                    avs_write,
    input  wire logic [31:0]             avs_writedata,
    input  wire logic [3:0]              avs_byteenable,
    output logic      [31:0]             avs_readdata,
    output logic                         avs_waitrequest
);
    // Word width and depth follow the organisation chosen by the parameters
    localparam int DATA_W = LANES * LANE_W;
    localparam int DEPTH  = 1 << ADDR_W;

    typedef struct packed {
        // Pin synchronisers and the levels they settle on
        logic [2:0]            sleepSync;
        logic [2:0]            orderSync;
        logic                  sleepState;
        logic                  orderState;

        // Access in progress and the read pipeline
        sbs_pkg::sbs_kind_t    kind;
        logic [ADDR_W-3:0]     base;
        logic                  readActive;
        logic [DATA_W-1:0]     dataOut;
        logic                  dataOe;

        // Write beat waiting for its data edge
        logic                  wrPend;
        logic [ADDR_W-1:0]     wrAddr;
        logic [LANES-1:0]      wrMask;

        // Configuration and status seen by software
        logic                  wideMode;
        logic                  lastAbort;
        logic [LANES-1:0]      lastMask;

        // Register slave handshake
        logic                  avWait;
        logic [31:0]           avRdata;
    } sbs_state_t;

    sbs_state_t st_reg;
    sbs_state_t st_next;

    // Storage array, one word per address, lane a in the lowest bits
    logic [DATA_W-1:0] mem [DEPTH];

    // The top drives every input member of the carrier
    sbs_core_if #(.LANES(LANES)) core ();

    // ************************************************************
    // Leaf modules
    // ************************************************************
    // Lane decoder: purely combinational from the sampled strobes
    sbs_lane_decode u_decode (
        .core (core)
    );

    // Burst counter: holds seed and beat number of the current burst
    sbs_burst_count u_count (
        .clk     (clk),
        .sys_rst (sys_rst),
        .core    (core)
    );

    // ************************************************************
    // Command decode
    // ************************************************************
    logic              inputsLive;
    logic              newCycle;
    logic              deselect;
    logic              burstStep;
    logic [ADDR_W-1:0] accessAddr;
    logic [31:0]       statusWord;
    logic              avReq;

    // Strobes are plain same-clock inputs, taken at the edge only
    assign core.writeSelN   = writeSelectN;
    // Lane i of the strobes maps to the i-th data slice
    assign core.laneN       = {byte_lane_d_write_n, byte_lane_c_write_n,
                               byte_lane_b_write_n, byte_lane_a_write_n};
    assign core.wideMode    = st_reg.wideMode;

    // Order comes from the settled level, never from the raw pin
    assign core.interleaved = st_reg.orderState;
    assign core.seed        = address[1:0];

    // Sleep only takes hold once the synchroniser agrees, so the pins
    // keep being taken for a few edges after it rises.
    assign inputsLive = ~st_reg.sleepState;
    assign newCycle   = inputsLive && !advance && !chipSelectN;
    assign deselect   = inputsLive && !advance && chipSelectN;
    // A continue with no access running does nothing, as after a deselect
    assign burstStep  = inputsLive && advance && (st_reg.kind != sbs_pkg::KIND_IDLE);

    assign core.load    = newCycle;
    assign core.advance = burstStep;

    // ************************************************************
    // Beat address and status
    // ************************************************************
    // External address on a load, counter-built address on a continue
    always_comb begin
        if (newCycle) begin
            accessAddr = address;
        end else begin
            accessAddr = {st_reg.base, core.nextLow};
        end
    end

    // Status is assembled live; only the read answer registers it
    always_comb begin
        statusWord = '0;
        statusWord[sbs_pkg::STAT_SLEEP_POS] = st_reg.sleepState;
        statusWord[sbs_pkg::STAT_ORDER_POS] = st_reg.orderState;
        statusWord[sbs_pkg::STAT_LOW_POS +: 2] = core.curLow;
        statusWord[sbs_pkg::STAT_MASK_POS +: LANES] = st_reg.lastMask;
        statusWord[sbs_pkg::STAT_ABORT_POS] = st_reg.lastAbort;
        statusWord[sbs_pkg::STAT_WRPEND_POS] = st_reg.wrPend;
    end

    assign avReq = avs_read || avs_write;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        st_next = st_reg;

        // **********
        // Pin synchronisers
        // **********
        // Asynchronous pins: three stages, a change counts when 2 and 3 agree
        st_next.sleepSync = {st_reg.sleepSync[1:0], sleep_request};
        // An undriven burst-order pin is pulled up
        st_next.orderSync = {st_reg.orderSync[1:0],
                             burstOrderPin || !burstOrderDriven};

        // A lone disagreeing sample leaves the settled level alone
        if (st_reg.sleepSync[1] == st_reg.sleepSync[2]) begin
            st_next.sleepState = st_reg.sleepSync[2];
        end
        // Treated as static; a change is merely followed after sync delay
        if (st_reg.orderSync[1] == st_reg.orderSync[2]) begin
            st_next.orderState = st_reg.orderSync[2];
        end

        // **********
        // Access decode
        // **********
        // A write beat is pending for exactly one edge
        st_next.wrPend = 1'b0;
        if (newCycle) begin
            st_next.base = address[ADDR_W-1:2];
            if (writeSelectN) begin
                st_next.kind       = sbs_pkg::KIND_READ;
                st_next.readActive = 1'b1;
            end else begin
                st_next.kind       = sbs_pkg::KIND_WRITE;
                st_next.readActive = 1'b0;
            end
        end else if (deselect) begin
            st_next.kind       = sbs_pkg::KIND_IDLE;
            st_next.readActive = 1'b0;
        end

        // **********
        // Write beats
        // **********
        // Lanes latched now, data taken on the next edge; strobes are
        // decoded afresh on every beat of a write burst
        if ((newCycle && !writeSelectN) ||
            (burstStep && st_reg.kind == sbs_pkg::KIND_WRITE)) begin
            st_next.lastMask  = core.laneMask;
            st_next.wrMask    = core.laneMask;
            st_next.lastAbort = core.writeAbort;
            st_next.wrPend    = !core.writeAbort;
            st_next.wrAddr    = accessAddr;
        end

        // **********
        // Read beats
        // **********
        // A write landing on this same edge is not seen: old data is read
        if (st_next.readActive && (newCycle || burstStep)) begin
            st_next.dataOut = mem[accessAddr];
        end

        // Drive only on a read, with output enable low and no sleep
        st_next.dataOe = st_next.readActive && !outputEnableN &&
                         !st_next.sleepState;

        // **********
        // Register slave
        // **********
        // Waitrequest idles high, so every request sees one wait cycle
        st_next.avWait = 1'b1;
        if (avReq && st_reg.avWait) begin
            st_next.avWait  = 1'b0;
            st_next.avRdata = '0;
            if (avs_read) begin
                if (avs_address == sbs_pkg::REG_CTRL_OFS) begin
                    st_next.avRdata[sbs_pkg::CTRL_WIDE_POS] = st_reg.wideMode;
                end else if (avs_address == sbs_pkg::REG_STATUS_OFS) begin
                    st_next.avRdata = statusWord;
                end else begin
                    // Unmapped offsets read as zero
                    st_next.avRdata = '0;
                end
            end
        end

        // The write lands on the answer edge, while the master still holds it
        if (avs_write && !st_reg.avWait && avs_byteenable[0] &&
            avs_address == sbs_pkg::REG_CTRL_OFS) begin
            st_next.wideMode = avs_writedata[sbs_pkg::CTRL_WIDE_POS];
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge clk) begin
        // Reset leaves the pins undriven and the slave waiting
        if (sys_rst) begin
            st_reg            <= '0;
            st_reg.sleepSync  <= sbs_pkg::SYNC_RESET;
            st_reg.orderSync  <= sbs_pkg::ORDER_SYNC_RESET;
            st_reg.sleepState <= sbs_pkg::SLEEP_RESET;
            st_reg.orderState <= sbs_pkg::ORDER_RESET;
            st_reg.kind       <= sbs_pkg::KIND_IDLE;
            st_reg.wideMode   <= WIDE_DEFAULT;
            st_reg.avWait     <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // Array kept out of reset: contents are undefined after power-up anyway
    always_ff @(posedge clk) begin
        if (!sys_rst && st_reg.wrPend) begin
            for (int i = 0; i < LANES; i++) begin
                // Lanes outside the latched mask keep their old contents
                if (st_reg.wrMask[i]) begin
                    mem[st_reg.wrAddr][i*LANE_W +: LANE_W] <= dataIn[i*LANE_W +: LANE_W];
                end
            end
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign dataOut         = st_reg.dataOut;
    assign dataOe          = st_reg.dataOe;

    assign avs_readdata    = st_reg.avRdata;
    assign avs_waitrequest = st_reg.avWait;
endmodule

/* File: testbench/sbs_checker.sv */
// Concurrent checks on the pins and register slave of sbs_top.
// Assumes it is bound into sbs_top; one clk domain, sys_rst sync high.
`timescale 1ns/1ps
module sbs_checker #(
    parameter int LANE_W = 9,
    parameter int LANES  = 4
) (
    input wire logic                    clk,
    input wire logic                    sys_rst,
    input wire logic                    chipSelectN,
    input wire logic                    advance,
    input wire logic                    writeSelectN,
    input wire logic                    outputEnableN,
    input wire logic                    sleep_request,
    input wire logic [LANES*LANE_W-1:0] dataOut,
    input wire logic                    dataOe,
    input wire logic                    avs_read,
    input wire logic                    avs_write,
    input wire logic                    avs_waitrequest
);
    // ************
    // Properties
    // ************
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Sleep pin crosses a 3-flop sync, so five quiet samples mean awake
    sequence s_awake; !sleep_request[*5]; endsequence
    sequence s_load; !chipSelectN && !advance; endsequence
    property p_sleep_float; sleep_request[*5] |-> !dataOe; endproperty
    property p_desel; s_awake ##0 (chipSelectN && !advance) |=> !dataOe; endproperty
    property p_oe_off; outputEnableN |=> !dataOe; endproperty
    property p_read_drive;
        s_awake ##0 s_load ##0 (writeSelectN && !outputEnableN) |=> dataOe;
    endproperty
    property p_write_float; s_awake ##0 s_load ##0 !writeSelectN |=> !dataOe; endproperty
    property p_out_hold;
        (!advance && (chipSelectN || !writeSelectN)) |=> $stable(dataOut);
    endproperty
    property p_answer; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    property p_one_cycle; !avs_waitrequest |=> avs_waitrequest; endproperty
    a_sleep_float: assert property (p_sleep_float) else $error("pins driven in sleep");
    a_desel: assert property (p_desel) else $error("pins driven when deselected");
    a_oe_off: assert property (p_oe_off) else $error("pins driven with oe high");
    a_read_drive: assert property (p_read_drive) else $error("read not driven");
    a_write_float: assert property (p_write_float) else $error("driven on write");
    a_out_hold: assert property (p_out_hold) else $error("read data moved");
    a_answer: assert property (p_answer) else $error("bus answer late");
    a_one_cycle: assert property (p_one_cycle) else $error("bus answer too long");
endmodule

/* File: testbench/sbs_ctrl_model.sv */
// Memory-controller model driving the command and data pins of the SRAM.
// Assumes the bench calls one task at a time; signals move after posedge.
`timescale 1ns/1ps
module sbs_ctrl_model #(
    parameter int AW = 8
) (
    input  wire logic          clk,
    input  wire logic [35:0]   dataOut,
    input  wire logic          dataOe,
    output logic               csN,
    output logic               adv,
    output logic               weN,
    output logic [3:0]         laneN,
    output logic               oeN,
    output logic [AW-1:0]      addr,
    output logic [35:0]        dataIn
);
    logic [35:0] q [4];
    logic        seenOe;
    initial begin
        csN = 1'b1;
        adv = 1'b0;
        weN = 1'b1;
        laneN = 4'hf;
        oeN = 1'b1;
        addr = '0;
        dataIn = '0;
    end
    // Output enable is dropped with the write so both sides never fight
    task automatic wr(input logic [AW-1:0] a, input logic [3:0] s, input logic [35:0] d);
        @(posedge clk);
        csN <= 1'b0;
        adv <= 1'b0;
        weN <= 1'b0;
        laneN <= s;
        oeN <= 1'b1;
        addr <= a;
        @(posedge clk);
        csN <= 1'b1;
        dataIn <= d;
        @(posedge clk);
        // Released data shows the inverse, never a stale copy
        dataIn <= ~d;
    endtask
    task automatic rd(input logic [AW-1:0] a, input logic oe, input int n);
        @(posedge clk);
        csN <= 1'b0;
        adv <= 1'b0;
        weN <= 1'b1;
        oeN <= oe;
        addr <= a;
        @(posedge clk);
        adv <= (n > 1);
        csN <= 1'b1;
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            q[i] = dataOut;
            if (i == 0) seenOe = dataOe;
            if (i == n - 2) adv <= 1'b0;
        end
    endtask
endmodule

/* File: testbench/sync_sram_io_byte_write_burst_tb.sv */
// Self-checking bench for sbs_top: lanes, burst order, sleep, registers.
// Assumes the controller model drives the pins; the bench owns the bus.
`timescale 1ns/1ps
module sync_sram_io_byte_write_burst_tb;
    localparam int AW = 8;
    localparam logic [3:0] PAT [6] = '{4'he, 4'hd, 4'hb, 4'h7, 4'h0, 4'hf};
    logic          clk;
    logic          sys_rst;
    logic          sleepReq;
    logic          orderPin;
    logic          orderDriven;
    logic [3:0]    avsAddr;
    logic          avsRead;
    logic          avsWrite;
    logic [31:0]   avsWdata;
    logic [31:0]   avsRdata;
    logic          avsWait;
    logic [31:0]   rdq;
    logic [35:0]   dOut;
    logic [35:0]   dIn;
    logic          dOe;
    logic          csN;
    logic          adv;
    logic          weN;
    logic          oeN;
    logic [3:0]    laneN;
    logic [AW-1:0] addr;
    int            fail_count;
    int            n_checks;
    sbs_top #(.ADDR_W(AW)) dut_u (.clk(clk), .sys_rst(sys_rst), .chipSelectN(csN),
        .advance(adv), .writeSelectN(weN), .byte_lane_a_write_n(laneN[0]),
        .byte_lane_b_write_n(laneN[1]), .byte_lane_c_write_n(laneN[2]),
        .byte_lane_d_write_n(laneN[3]), .outputEnableN(oeN), .sleep_request(sleepReq),
        .burstOrderPin(orderPin), .burstOrderDriven(orderDriven), .address(addr),
        .dataIn(dIn), .dataOut(dOut), .dataOe(dOe), .avs_address(avsAddr),
        .avs_read(avsRead), .avs_write(avsWrite), .avs_writedata(avsWdata),
        .avs_byteenable(4'hf), .avs_readdata(avsRdata), .avs_waitrequest(avsWait));
    sbs_ctrl_model #(.AW(AW)) ctl_u (.clk(clk), .dataOut(dOut), .dataOe(dOe), .csN(csN),
        .adv(adv), .weN(weN), .laneN(laneN), .oeN(oeN), .addr(addr), .dataIn(dIn));
    // ************
    // Shared tasks
    // ************
    function automatic logic [35:0] dat(input int j);
        return 36'h111111111 * 36'(j + 1);
    endfunction
    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic avs(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        avsRead <= !w;
        avsWrite <= w;
        avsAddr <= a;
        avsWdata <= d;
        // No cycle limit here: the watchdog ends a hung wait
        do begin
            @(posedge clk);
        end while (avsWait !== 1'b0);
        rdq = avsRdata;
        avsRead <= 1'b0;
        avsWrite <= 1'b0;
    endtask
    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // ************
    // Scenarios
    // ************
    task automatic t_regs();
        avs(1'b0, sbs_pkg::REG_CTRL_OFS, 32'h0);
        check(36'(rdq[sbs_pkg::CTRL_WIDE_POS]), 36'h1);
        avs(1'b1, 4'h8, 32'hffffffff);
        avs(1'b0, 4'h8, 32'h0);
        check(36'(rdq), 36'h0);
        avs(1'b0, sbs_pkg::REG_STATUS_OFS, 32'h0);
        check(36'(rdq[sbs_pkg::STAT_ORDER_POS]), 36'h1);
    endtask
    task automatic t_lanes(input logic wide);
        logic [3:0]  s;
        logic [3:0]  m;
        logic [35:0] mk;
        logic [35:0] exp;
        avs(1'b1, sbs_pkg::REG_CTRL_OFS, {31'h0, wide});
        mk = wide ? 36'hfffffffff : 36'h00003ffff;
        for (int k = 0; k < 6; k++) begin
            // Narrow mode keeps lanes c and d low to show they are ignored
            s = wide ? PAT[k] : {2'b00, PAT[k][1:0]};
            m = ~s & (wide ? 4'hf : 4'h3);
            ctl_u.wr(8'h20 + AW'(k), 4'h0, 36'h123456789);
            ctl_u.wr(8'h20 + AW'(k), s, 36'hfedcba987);
            exp = 36'h123456789;
            for (int i = 0; i < 4; i++)
                if (m[i]) exp[9*i +: 9] = 9'(36'hfedcba987 >> (9 * i));
            ctl_u.rd(8'h20 + AW'(k), 1'b0, 1);
            check(ctl_u.q[0] & mk, exp & mk);
            avs(1'b0, sbs_pkg::REG_STATUS_OFS, 32'h0);
            check(36'({rdq[sbs_pkg::STAT_ABORT_POS], rdq[sbs_pkg::STAT_MASK_POS +: 4]}),
                36'({m == 4'h0, m}));
        end
    endtask
    task automatic t_burst(input logic drv, input logic pin, input logic inter);
        logic [1:0] lo;
        orderDriven <= drv;
        orderPin <= pin;
        repeat (8) @(posedge clk);
        avs(1'b0, sbs_pkg::REG_STATUS_OFS, 32'h0);
        check(36'(rdq[sbs_pkg::STAT_ORDER_POS]), 36'(inter));
        for (int j = 0; j < 4; j++) ctl_u.wr(8'h40 + AW'(j), 4'h0, dat(j));
        for (int s = 0; s < 4; s++) begin
            ctl_u.rd(8'h40 + AW'(s), 1'b0, 4);
            for (int i = 0; i < 4; i++) begin
                lo = inter ? 2'(s ^ i) : 2'(s + i);
                check(ctl_u.q[i], dat(lo));
            end
        end
    endtask
    task automatic t_sleep_oe();
        sleepReq <= 1'b1;
        repeat (6) @(posedge clk);
        avs(1'b0, sbs_pkg::REG_STATUS_OFS, 32'h0);
        check(36'(rdq[sbs_pkg::STAT_SLEEP_POS]), 36'h1);
        ctl_u.rd(8'h40, 1'b0, 1);
        check(36'(ctl_u.seenOe), 36'h0);
        ctl_u.wr(8'h40, 4'h0, 36'h0);
        sleepReq <= 1'b0;
        repeat (6) @(posedge clk);
        ctl_u.rd(8'h40, 1'b1, 1);
        check(36'(ctl_u.seenOe), 36'h0);
        ctl_u.rd(8'h40, 1'b0, 1);
        check(ctl_u.q[0], dat(0));
        check(36'(ctl_u.seenOe), 36'h1);
        @(posedge clk);
        check(36'(dOe), 36'h0);
    endtask
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        repeat (30000) @(posedge clk);
        fail_count++;
        print_verdict();
    end
    initial begin
        sys_rst = 1'b1;
        sleepReq = 1'b0;
        orderPin = 1'b0;
        orderDriven = 1'b0;
        avsAddr = 4'h0;
        avsRead = 1'b0;
        avsWrite = 1'b0;
        avsWdata = 32'h0;
        fail_count = 0;
        n_checks = 0;
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        t_regs();
        t_lanes(1'b0);
        t_lanes(1'b1);
        t_burst(1'b0, 1'b0, 1'b1);
        t_burst(1'b1, 1'b1, 1'b1);
        t_burst(1'b1, 1'b0, 1'b0);
        t_sleep_oe();
        print_verdict();
    end
endmodule
bind sbs_top sbs_checker #(.LANE_W(LANE_W), .LANES(LANES)) chk_u (.clk(clk),
    .sys_rst(sys_rst), .chipSelectN(chipSelectN), .advance(advance),
    .writeSelectN(writeSelectN), .outputEnableN(outputEnableN),
    .sleep_request(sleep_request), .dataOut(dataOut), .dataOe(dataOe),
    .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest));
